// File: dce_executor.v
`include "dce_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module dce_executor #(
   parameter CLK_MHZ  = 100,
   parameter SPT      = 17
) (
   // Clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // Host byte handshake
   input  wire       host_req,
   input  wire [7:0] host_data,
   output reg        host_ack,
   output reg        cmd_done,
   output reg  [7:0] sense_code,
   // Drive sector engine
   output reg        op_start,
   output reg  [2:0] op_kind,
   output reg        op_recal,
   output reg        op_bad_flag,
   output reg        op_write_data,
   output reg        op_servo_gap,
   output reg  [4:0] op_interleave,
   output reg  [7:0] op_fill,
   output reg  [3:0] op_step_rate,
   output reg        op_drive,
   output reg [15:0] phys_cyl,
   output reg  [3:0] phys_head,
   output reg  [7:0] phys_sector,
   input  wire       sector_done,
   input  wire       sector_err,
   input  wire [4:0] burst_len,
   input  wire       op_finished,
   input  wire [7:0] buffer_pattern,
   input  wire       buffered_step,
   // Data path gating and drive controls
   output reg        xfer_to_host,
   output reg        reduced_wc,
   output reg  [1:0] precomp_sel,
   output reg [15:0] servo_gap_cycles
);
   // Operation kinds
   localparam K_FMT = 3'h0, K_RD = 3'h1, K_WR = 3'h2, K_SEEK = 3'h3;
   // One-hot states
   localparam S_CDB = 6'h01, S_PARM = 6'h02, S_START = 6'h04;
   localparam S_RUN = 6'h08, S_DONE = 6'h10, S_WAIT = 6'h20;
   localparam [15:0] SERVO_CYC = `DCE_SERVO_US * CLK_MHZ;

   localparam [20:0] SPT_W = SPT;

   // Sequencer state and byte counter
   reg  [5:0]  state_reg;
   reg  [2:0]  cnt_reg;

   // Received command block, byte 0 is the opcode
   reg  [7:0]  cdb_reg [0:5];

   // Shared drive parameter set for both drives
   reg  [15:0] p_cyl_reg;
   reg  [15:0] p_rwc_reg;
   reg  [15:0] p_pre_reg;
   reg  [3:0]  p_heads_reg;
   reg  [3:0]  p_ecc_reg;

   // Transfer progress
   reg  [20:0] lba_reg;
   reg  [8:0]  left_reg;
   reg         retried_reg;
   integer     i;

   wire [7:0] opc   = cdb_reg[0];
   wire [7:0] ctl   = cdb_reg[5];
   wire       is_rd = (opc == `DCE_OP_READ) || (opc == `DCE_OP_VERIFY);
   wire       is_fmt = (opc == `DCE_OP_FMT_TRACK) || (opc == `DCE_OP_FMT_BAD);
   wire       no_retry = ctl[`DCE_CB_NORETRY];
   wire       ecc_opt  = ctl[`DCE_CB_ECCOPT];
   wire       corr     = (burst_len <= {1'b0, p_ecc_reg});

   // Linear address to physical address
   function [36:0] dce_map;
      input [20:0] lba;
      input [3:0]  heads;
      reg   [20:0] trk;
      reg   [20:0] hd21;
      reg   [20:0] cyl;
      reg   [20:0] hd;
      reg   [20:0] sec;
      begin
         // Track count first, then split it over the heads
         hd21 = {17'h0, heads};
         trk = lba / SPT_W;
         cyl = trk / hd21;
         hd = trk % hd21;
         sec = lba % SPT_W;
         dce_map = {cyl, hd[7:0], sec[7:0]};
      end
   endfunction
   wire [36:0] map = dce_map(lba_reg, p_heads_reg);
   wire [15:0] map_cyl = map[31:16];

   // Main sequencer
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         // Sequencer and command bytes
         state_reg <= S_CDB;
         cnt_reg <= 3'h0;
         for (i = 0; i < 6; i = i + 1)
            cdb_reg[i] <= 8'h00;

         // Default drive parameters
         p_cyl_reg <= `DCE_DEF_CYL;
         p_heads_reg <= `DCE_DEF_HEADS;
         p_rwc_reg <= `DCE_DEF_RWC;
         p_pre_reg <= `DCE_DEF_PRE;
         p_ecc_reg <= `DCE_DEF_ECC;
         lba_reg <= 21'h0;
         left_reg <= 9'h0;
         retried_reg <= 1'b0;

         // Host side outputs
         host_ack <= 1'b0;
         cmd_done <= 1'b0;
         sense_code <= `DCE_ERR_NONE;

         // Sector engine controls
         op_start <= 1'b0;
         op_kind <= K_RD;
         op_recal <= 1'b0;
         op_bad_flag <= 1'b0;
         op_write_data <= 1'b0;
         op_servo_gap <= 1'b0;
         op_interleave <= 5'h0;
         op_fill <= `DCE_FILL_DEFAULT;
         op_step_rate <= 4'h0;
         op_drive <= 1'b0;
         phys_cyl <= 16'h0;
         phys_head <= 4'h0;
         phys_sector <= 8'h0;

         // Data gating and write controls
         xfer_to_host <= 1'b0;
         reduced_wc <= 1'b0;
         precomp_sel <= `DCE_PRE_5NS;
         servo_gap_cycles <= 16'h0;
      end else begin
         // Strobes default low
         host_ack <= 1'b0;
         cmd_done <= 1'b0;
         op_start <= 1'b0;

         // Physical address and write controls follow the current sector
         phys_cyl <= map_cyl;
         phys_head <= map[11:8];
         phys_sector <= map[7:0];
         reduced_wc <= (map_cyl >= p_rwc_reg);
         if (map_cyl >= {1'b0, p_pre_reg[14:0]})
            precomp_sel <= `DCE_PRE_10NS;
         else
            precomp_sel <= p_pre_reg[15] ? `DCE_PRE_0NS : `DCE_PRE_5NS;
         case (state_reg)
            // Collect six bytes, one ack each
            S_CDB: begin
               if (host_req && !host_ack) begin
                  host_ack <= 1'b1;
                  cdb_reg[cnt_reg] <= host_data;
                  cnt_reg <= cnt_reg + 3'h1;
                  if (cnt_reg == `DCE_CDB_LAST) begin
                     cnt_reg <= 3'h0;
                     state_reg <= (cdb_reg[0] == `DCE_OP_INIT) ? S_PARM : S_START;
                  end
               end
            end

            // Parameter bytes C,H,W,P,E, MSB first
            S_PARM: begin
               if (host_req && !host_ack) begin
                  host_ack <= 1'b1;
                  cnt_reg <= cnt_reg + 3'h1;
                  case (cnt_reg)
                     3'h0: p_cyl_reg[15:8] <= host_data;
                     3'h1: p_cyl_reg[7:0] <= host_data;
                     3'h2: p_heads_reg <= host_data[3:0];
                     3'h3: p_rwc_reg[15:8] <= host_data;
                     3'h4: p_rwc_reg[7:0] <= host_data;
                     3'h5: p_pre_reg[15:8] <= host_data;
                     3'h6: p_pre_reg[7:0] <= host_data;
                     default: p_ecc_reg <= host_data[3:0];
                  endcase
                  if (cnt_reg == `DCE_PARM_LAST) begin
                     cnt_reg <= 3'h0;
                     sense_code <= `DCE_ERR_NONE;
                     state_reg <= S_DONE;
                  end
               end
            end

            // Decode and launch
            S_START: begin
               lba_reg <= {cdb_reg[1][4:0], cdb_reg[2], cdb_reg[3]};
               left_reg <= (cdb_reg[4] == 8'h00) ? 9'h100 : {1'b0, cdb_reg[4]};
               retried_reg <= 1'b0;
               sense_code <= `DCE_ERR_NONE;
               op_drive <= cdb_reg[1][5];
               op_step_rate <= ctl[3:0];
               op_interleave <= cdb_reg[4][4:0];
               op_recal <= is_fmt;
               op_bad_flag <= (opc == `DCE_OP_FMT_BAD);
               op_write_data <= (opc == `DCE_OP_FMT_TRACK);
               op_fill <= ctl[`DCE_CB_PATTERN] ? buffer_pattern : `DCE_FILL_DEFAULT;
               op_servo_gap <= is_fmt && ctl[`DCE_CB_SERVO];
               servo_gap_cycles <= (is_fmt && ctl[`DCE_CB_SERVO]) ? SERVO_CYC : 16'h0;
               xfer_to_host <= (opc == `DCE_OP_READ);
               if (is_fmt)
                  op_kind <= K_FMT;
               else if (is_rd)
                  op_kind <= K_RD;
               else if (opc == `DCE_OP_WRITE)
                  op_kind <= K_WR;
               else
                  op_kind <= K_SEEK;
               if (!is_fmt && !is_rd && opc != `DCE_OP_WRITE && opc != `DCE_OP_SEEK) begin
                  sense_code <= `DCE_ERR_INVALID;
                  state_reg <= S_DONE;
               end else begin
                  op_start <= 1'b1;
                  state_reg <= S_RUN;
               end
            end

            // Per-sector progress and error handling
            S_RUN: begin
               // Whole-operation commands end on the engine's finish
               if (opc == `DCE_OP_SEEK && buffered_step && op_finished) begin
                  state_reg <= S_DONE;
               end else if (op_finished && (is_fmt || opc == `DCE_OP_SEEK)) begin
                  state_reg <= S_DONE;
               end else if (sector_done && (is_rd || opc == `DCE_OP_WRITE)) begin
                  // Write faults are always hard
                  if (sector_err && opc == `DCE_OP_WRITE) begin
                     sense_code <= `DCE_ERR_UNCORR;
                     state_reg <= S_DONE;
                  end else if (sector_err && !corr) begin
                     // Burst too long: withhold this sector
                     sense_code <= `DCE_ERR_UNCORR;
                     xfer_to_host <= 1'b0;
                     state_reg <= S_DONE;
                  end else if (sector_err && opc == `DCE_OP_VERIFY && !ecc_opt
                               && !retried_reg && !no_retry) begin
                     retried_reg <= 1'b1;
                     op_start <= 1'b1;
                  end else if (sector_err && (opc == `DCE_OP_VERIFY || ecc_opt)) begin
                     sense_code <= `DCE_ERR_CORR;
                     state_reg <= S_DONE;
                  end else begin
                     // Good or silently corrected sector: advance
                     retried_reg <= 1'b0;
                     lba_reg <= lba_reg + 21'h1;
                     left_reg <= left_reg - 9'h1;
                     if (left_reg == 9'h1)
                        state_reg <= S_DONE;
                     else
                        op_start <= 1'b1;
                  end
               end
            end

            // Completion strobe, wait for host to drop request
            S_DONE: begin
               cmd_done <= 1'b1;
               state_reg <= S_WAIT;
            end

            // Rearm only once the host has let go of its request
            S_WAIT: begin
               xfer_to_host <= 1'b0;
               if (!host_req)
                  state_reg <= S_CDB;
            end

            // Stray code: back to collecting
            default: state_reg <= S_CDB;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: dce_regs.vh
`ifndef DCE_REGS_VH
`define DCE_REGS_VH
// Opcodes
`define DCE_OP_FMT_TRACK   8'h06
`define DCE_OP_FMT_BAD     8'h07
`define DCE_OP_READ        8'h08
`define DCE_OP_VERIFY      8'h09
`define DCE_OP_WRITE       8'h0A
`define DCE_OP_SEEK        8'h0B
`define DCE_OP_INIT        8'h0C
// Control byte fields
`define DCE_CB_NORETRY     7
`define DCE_CB_ECCOPT      6
`define DCE_CB_PATTERN     5
`define DCE_CB_SERVO       4
// Parameter defaults
`define DCE_DEF_CYL        16'h0099
`define DCE_DEF_HEADS      4'h4
`define DCE_DEF_RWC        16'h0080
`define DCE_DEF_PRE        16'h0040
`define DCE_DEF_ECC        4'hB
// Fill pattern and precomp codes
`define DCE_FILL_DEFAULT   8'h6C
`define DCE_PRE_0NS        2'h0
`define DCE_PRE_5NS        2'h1
`define DCE_PRE_10NS       2'h2
// Error codes
`define DCE_ERR_NONE       8'h00
`define DCE_ERR_UNCORR     8'h11
`define DCE_ERR_CORR       8'h18
`define DCE_ERR_INVALID    8'h20
`define DCE_ERR_ADDR       8'h21
// Counts
`define DCE_CDB_LAST       3'h5
`define DCE_PARM_LAST      3'h7
`define DCE_SERVO_US       300
`endif

// File: dce_props.sv
`timescale 1ns/100ps
`default_nettype none
module dce_props (
   // Clock and reset
   input wire       clk,
   input wire       reset_n,
   // Host handshake
   input wire       host_req,
   input wire       host_ack,
   input wire       cmd_done,
   input wire [7:0] sense_code,
   // Sector engine
   input wire       op_start,
   input wire       sector_done,
   input wire       sector_err,
   input wire [4:0] burst_len,
   input wire [1:0] precomp_sel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Byte handshake
   a_ack_pulse: assert property (host_ack |=> !host_ack)
      else $error("ack held too long");
   a_ack_cause: assert property ($rose(host_ack) |-> $past(host_req))
      else $error("ack without request");
   a_ack_no_start: assert property (host_ack |-> !op_start)
      else $error("start while taking bytes");
   // Completion, status, start strobe and precomp code
   a_done_pulse: assert property (cmd_done |=> !cmd_done)
      else $error("done held too long");
   a_sense_hold: assert property (cmd_done |=> $stable(sense_code))
      else $error("status moved after done");
   a_done_quiet: assert property (cmd_done |-> !host_ack)
      else $error("byte taken at done");
   a_hard_stop: assert property (sector_done && sector_err && burst_len == 5'h1F
      |-> ##[1:4] (cmd_done && sense_code == 8'h11 || op_start))
      else $error("no stop after hard error");
   a_start_pulse: assert property (op_start |=> !op_start)
      else $error("start held too long");
   a_precomp_code: assert property (precomp_sel != 2'h3)
      else $error("bad precomp code");
   c_corr: cover property (cmd_done && sense_code == 8'h18);
   c_hard: cover property (cmd_done && sense_code == 8'h11);
   c_fault: cover property (sector_done && sector_err);
endmodule
`default_nettype wire

// File: dce_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
module dce_drive_model (
   // Clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // Executor side
   input  wire       op_start,
   input  wire [2:0] op_kind,
   input  wire       cmd_done,
   output reg        sector_done,
   output wire       sector_err,
   output wire [4:0] burst_len,
   output reg        op_finished,
   // Fault setup
   input  wire [8:0] err_at,
   input  wire [4:0] burst
);
   reg [2:0] pend_reg;
   reg [2:0] kind_reg;
   reg [8:0] cnt_reg;
   // Fault only on the chosen sector; length is junk otherwise
   assign sector_err = sector_done && cnt_reg == err_at;
   assign burst_len  = sector_err ? burst : ~burst;
   // Answer each start four cycles later
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_reg    <= 3'h0;
         kind_reg    <= 3'h0;
         cnt_reg     <= 9'h000;
         sector_done <= 1'b0;
         op_finished <= 1'b0;
      end else begin
         pend_reg    <= {pend_reg[1:0], op_start};
         sector_done <= pend_reg[2] && (kind_reg == 3'h1 || kind_reg == 3'h2);
         op_finished <= pend_reg[2] && (kind_reg == 3'h0 || kind_reg == 3'h3);
         if (op_start) kind_reg <= op_kind;
         if (cmd_done) cnt_reg <= 9'h000;
         else if (sector_done) cnt_reg <= cnt_reg + 9'h001;
      end
   end
endmodule
`default_nettype wire

// File: dce_executor_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dce_executor_tb;
   reg        clk = 1'b0;
   reg        reset_n = 1'b0;
   reg        host_req = 1'b0;
   reg  [7:0] host_data = 8'h00;
   reg  [8:0] err_at = 9'h1FF;
   reg  [4:0] burst = 5'h00;
   reg  [9:0] cap = 10'h000;
   reg        sd_d = 1'b0;
   wire       host_ack, cmd_done, op_start, sector_done, sector_err, op_finished;
   wire       op_bad_flag, op_write_data, xfer_to_host, reduced_wc;
   wire [7:0] sense_code, op_fill;
   wire [2:0] op_kind;
   wire [4:0] burst_len;
   wire [1:0] precomp_sel;
   integer    errors = 0, n_tests = 0, n_st = 0, n_xf = 0;
   always #5 clk = ~clk;
   dce_executor #(.CLK_MHZ(100), .SPT(17)) DUT (.clk, .reset_n, .host_req, .host_data,
      .host_ack, .cmd_done, .sense_code, .op_start, .op_kind, .op_recal(), .op_bad_flag,
      .op_write_data, .op_servo_gap(), .op_interleave(), .op_fill, .op_step_rate(),
      .op_drive(), .phys_cyl(), .phys_head(), .phys_sector(), .sector_done, .sector_err,
      .burst_len, .op_finished, .buffer_pattern(8'h5A), .buffered_step(1'b1),
      .xfer_to_host, .reduced_wc, .precomp_sel, .servo_gap_cycles());
   dce_drive_model DRV (.clk, .reset_n, .op_start, .op_kind, .cmd_done, .sector_done,
      .sector_err, .burst_len, .op_finished, .err_at, .burst);
   // Count starts and sectors released to the host; latch format controls
   always @(posedge clk) begin
      if (op_start) n_st <= n_st + 1;
      if (op_start) cap <= {op_bad_flag, op_write_data, op_fill};
      sd_d <= sector_done;
      if (sd_d && xfer_to_host) n_xf <= n_xf + 1;
   end
   task close_out;
      begin
         if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [15:0] e, input [15:0] s);
      begin
         n_tests = n_tests + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task tmo(input [63:0] nm);
      begin
         errors = errors + 1;
         $display("[FAIL] %0s expected 1 seen 0", nm);
         close_out;
      end
   endtask
   // One byte: hold until ack is sampled, then release for a cycle
   task put(input [7:0] b);
      integer i;
      begin
         host_req <= 1'b1;
         host_data <= b;
         i = 0;
         @(posedge clk);
         while (host_ack !== 1'b1 && i < 20) begin
            @(posedge clk);
            i = i + 1;
         end
         if (i == 20) tmo("ack");
         host_req <= 1'b0;
         @(posedge clk);
      end
   endtask
   task done_wait;
      integer i;
      begin
         i = 0;
         while (cmd_done !== 1'b1 && i < 3000) begin
            @(posedge clk);
            i = i + 1;
         end
         if (i == 3000) tmo("done");
      end
   endtask
   // Six-byte command at address 0, then status, start count and data flow
   task cmd(input [7:0] op, input [7:0] n, input [7:0] c, input [8:0] ea,
            input [4:0] bl, input [7:0] es, input [15:0] ns, input xe);
      integer b, x;
      begin
         err_at <= ea;
         burst <= bl;
         b = n_st;
         x = n_xf;
         put(op);
         repeat (3) put(8'h00);
         put(n);
         put(c);
         done_wait;
         chk("sense", es, sense_code);
         chk("starts", ns, n_st - b);
         chk("xfer", xe, n_xf != x);
         @(posedge clk);
      end
   endtask
   task init(input [15:0] w, input [15:0] p);
      begin
         put(8'h0C);
         repeat (5) put(8'h00);
         put(8'h01);
         put(8'h32);
         put(8'h06);
         put(w[15:8]);
         put(w[7:0]);
         put(p[15:8]);
         put(p[7:0]);
         put(8'h04);
         done_wait;
         chk("sense", 8'h00, sense_code);
         @(posedge clk);
      end
   endtask
   task t_params;
      begin
         chk("fill", 8'h6C, op_fill);
         chk("rwc", 0, reduced_wc);
         chk("precomp", 1, precomp_sel);
         init(16'h0000, 16'h8001);
         cmd(8'h08, 1, 8'hC0, 0, 5, 8'h11, 1, 0);
         chk("rwc", 1, reduced_wc);
         chk("precomp", 0, precomp_sel);
         init(16'h0001, 16'h0000);
         cmd(8'h08, 1, 8'hC0, 0, 4, 8'h18, 1, 1);
         chk("rwc", 0, reduced_wc);
         chk("precomp", 2, precomp_sel);
      end
   endtask
   task t_transfer;
      begin
         cmd(8'h08, 2, 8'h80, 9'h1FF, 0, 8'h00, 2, 1);
         cmd(8'h08, 0, 8'h80, 9'h1FF, 0, 8'h00, 256, 1);
         cmd(8'h08, 3, 8'h80, 1, 31, 8'h11, 2, 1);
         cmd(8'h08, 1, 8'h80, 0, 3, 8'h00, 1, 1);
         cmd(8'h0A, 2, 8'h80, 0, 31, 8'h11, 1, 0);
         cmd(8'h09, 1, 8'h00, 0, 3, 8'h00, 2, 0);
         cmd(8'h09, 1, 8'h40, 0, 3, 8'h18, 1, 0);
      end
   endtask
   task t_other;
      begin
         cmd(8'h06, 5, 8'h00, 9'h1FF, 0, 8'h00, 1, 0);
         chk("flags", 10'h16C, cap);
         cmd(8'h06, 16, 8'h20, 9'h1FF, 0, 8'h00, 1, 0);
         chk("fill", 8'h5A, cap[7:0]);
         cmd(8'h07, 31, 8'h00, 9'h1FF, 0, 8'h00, 1, 0);
         chk("flags", 2'h2, cap[9:8]);
         cmd(8'h0B, 0, 8'h00, 9'h1FF, 0, 8'h00, 1, 0);
         cmd(8'h01, 0, 8'h00, 9'h1FF, 0, 8'h20, 0, 0);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_params;
      t_transfer;
      t_other;
      close_out;
   end
endmodule
bind dce_executor dce_props u_props (.clk, .reset_n, .host_req, .host_ack, .cmd_done,
   .sense_code, .op_start, .sector_done, .sector_err, .burst_len, .precomp_sel);
`default_nettype wire
